// >>> pso_equip.sv
// test equipment model on the output and sync connectors
`timescale 1ns/1ps
module pso_equip (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // connectors
  input wire logic pulse_out,
  input wire logic sync_out,
  output logic overload_pin,
  // bench control and measurements
  input wire logic ovl_cmd,
  output logic [15:0] p_hi,
  output logic [15:0] p_per,
  output logic [15:0] s_hi
);
  logic [15:0] pc;
  logic [15:0] sc;
  logic pl;
  logic sl;
  // external voltage is applied whenever commanded, whatever the output state
  assign overload_pin = ovl_cmd;
  // cycle counts restart at each rising edge of the observed line
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pc <= 16'h0000;
      sc <= 16'h0000;
      pl <= 1'b0;
      sl <= 1'b0;
      p_hi <= 16'h0000;
      p_per <= 16'h0000;
      s_hi <= 16'h0000;
    end else begin
      pl <= pulse_out;
      sl <= sync_out;
      pc <= (pulse_out && !pl) ? 16'h0001 : pc + 16'h0001;
      sc <= (sync_out && !sl) ? 16'h0001 : sc + 16'h0001;
      if (pulse_out && !pl) p_per <= pc;
      if (!pulse_out && pl) p_hi <= pc;
      if (!sync_out && sl) s_hi <= sc;
    end
  end
endmodule // pso_equip

// >>> pso_output_ctrl.sv
// pulse generator, sync selector, output enable and range control with an apb register file
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
module pso_output_ctrl import pso_pkg::*; #(
  parameter logic [CNT_W-1:0] P_PERIOD_MAX = PERIOD_MAX_CYC,
  parameter logic [CNT_W-1:0] P_WSTEP_A = WSTEP_A_CYC,
  parameter logic [CNT_W-1:0] P_WSTEP_B = WSTEP_B_CYC,
  parameter logic [CNT_W-1:0] P_PERIOD_DEF = PERIOD_DEF_CYC,
  parameter logic [CNT_W-1:0] P_WIDTH_DEF = WIDTH_DEF_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // waveform generators and amplitude logic on this clock
  input wire pso_evt_t evt,
  input wire logic [RANGE_W-1:0] range_req,
  // overload detector pin
  input wire logic overload_pin,
  // output stage
  output logic out_en,
  output logic wave_invert,
  output logic [RANGE_W-1:0] range_code,
  output logic [2:0] edge_cycles,
  output logic pulse_out,
  output logic sync_out
);

  pso_state_t s;
  pso_state_t next_s;
  pso_apb_req_t req;

  function automatic logic [CNT_W-1:0] fn_min(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
    fn_min = (a < b) ? a : b;
  endfunction

  function automatic logic [CNT_W-1:0] fn_max(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
    fn_max = (a > b) ? a : b;
  endfunction

  // 1.6 times an edge count, rounded up to whole cycles
  function automatic logic [CNT_W-1:0] fn_edge_span(input logic [2:0] e);
    fn_edge_span = CNT_W'(({3'h0, e} * 6'h08 + 6'h04) / 6'h05);
  endfunction

  // largest edge count that fits a span of 1.6 edges, floor of 5/8
  function automatic logic [CNT_W-1:0] fn_edge_fit(input logic [CNT_W-1:0] span);
    fn_edge_fit = CNT_W'(({4'h0, span} * 40'h5) >> 3);
  endfunction

  // unmapped offsets answer with an error and ignore writes
  function automatic logic fn_mapped(input logic [7:0] a);
    fn_mapped = (a == OFS_CTRL) || (a == OFS_PER_LO) || (a == OFS_PER_HI) || (a == OFS_WID_LO) ||
                (a == OFS_WID_HI) || (a == OFS_DUTY) || (a == OFS_EDGE) || (a == OFS_STAT) ||
                (a == OFS_EWID_LO) || (a == OFS_EPER_LO);
  endfunction

  always_comb begin
    req.psel = psel;
    req.penable = penable;
    req.pwrite = pwrite;
    req.paddr = paddr;
    req.pwdata = pwdata;
  end

  logic wr;
  logic [CNT_W-1:0] p_c;
  logic [CNT_W-1:0] wmin;
  logic [CNT_W-1:0] w_req;
  logic [CNT_W-1:0] w_a;
  logic [CNT_W-1:0] e_fit;
  logic [CNT_W-1:0] e_c;
  logic [CNT_W-1:0] w_b;
  logic [CNT_W-1:0] span;
  logic [CNT_W+6:0] duty_prod;
  logic cont_sync;
  logic run_sync;
  logic sweep_fall;
  logic [31:0] rd;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;
  logic ovl_now;

  always_comb begin
    next_s = s;
    // a write lands only in the access cycle marked by the registered ready
    wr = req.psel && req.penable && s.pready && req.pwrite;
    ovl_now = s.ovl_pipe[1];

    // effective pulse timing, re-derived every cycle from the programmed values
    p_c = fn_max(fn_min(s.period, P_PERIOD_MAX), PERIOD_MIN_CYC);
    if (p_c <= P_WSTEP_A) begin
      wmin = WMIN_A_CYC;
    end else if (p_c <= P_WSTEP_B) begin
      wmin = WMIN_B_CYC;
    end else begin
      wmin = WMIN_C_CYC;
    end
    duty_prod = {7'h00, p_c} * {{CNT_W{1'b0}}, s.duty};
    w_req = s.by_duty ? CNT_W'(duty_prod / (CNT_W + 7)'(DUTY_FULL)) : s.width;
    w_a = fn_min(fn_max(w_req, wmin), p_c - wmin);
    // edge shrinks first so both the pulse and the gap hold 1.6 edges
    e_fit = fn_min(fn_edge_fit(w_a), fn_edge_fit(p_c - w_a));
    e_c = fn_max(fn_min({{(CNT_W-3){1'b0}}, s.edge_set}, e_fit), CNT_W'(1));
    span = fn_edge_span(e_c[2:0]);
    w_b = fn_min(fn_max(w_a, span), p_c - span);
    next_s.eff_period = p_c;
    next_s.eff_width = w_b;
    next_s.eff_edge = e_c[2:0];
    next_s.clamped = (w_b != w_req) || (e_c[2:0] != s.edge_set) || (p_c != s.period);

    // pulse counter; a shortened period wraps at once
    if (s.cnt >= s.eff_period - CNT_W'(1)) begin
      next_s.cnt = '0;
    end else begin
      next_s.cnt = s.cnt + CNT_W'(1);
    end
    next_s.pulse_out = (s.cnt < s.eff_width) ^ s.invert;

    // sync sources; a set follows its clear so a set in the same cycle wins
    if (evt.arb_half) begin
      next_s.arb_sync = 1'b0;
    end
    if (evt.arb_first) begin
      next_s.arb_sync = 1'b1;
    end
    if (s.marker_on) begin
      sweep_fall = evt.sweep_marker;
    end else begin
      sweep_fall = evt.sweep_mid;
    end
    if (sweep_fall) begin
      next_s.sweep_sync = 1'b0;
    end
    if (evt.sweep_start) begin
      next_s.sweep_sync = 1'b1;
    end
    // a gated burst keeps sync high until the output cycle in flight ends
    if (s.burst_gated) begin
      if (!evt.gate && evt.cycle_end) begin
        next_s.burst_sync = 1'b0;
      end
      if (evt.gate) begin
        next_s.burst_sync = 1'b1;
      end
    end else begin
      if (evt.burst_done) begin
        next_s.burst_sync = 1'b0;
      end
      if (evt.burst_start) begin
        next_s.burst_sync = 1'b1;
      end
    end

    case (s.func)
      FN_PULSE: cont_sync = s.cnt < (s.eff_period >> 1);
      FN_SINE, FN_RAMP: cont_sync = evt.carrier_high;
      FN_SQUARE: cont_sync = evt.carrier_high;
      FN_ARB: cont_sync = s.arb_sync;
      default: cont_sync = 1'b0;
    endcase
    // polarity is applied to the pulse only, never to the sync path
    if (s.sweep_on && s.marker_on) begin
      run_sync = s.sweep_sync;
    end else if (!s.sync_en || s.func == FN_NOISE || s.func == FN_DC) begin
      run_sync = 1'b0;
    end else if (s.sweep_on) begin
      run_sync = s.sweep_sync;
    end else if (s.burst_on && !s.burst_inf) begin
      run_sync = s.burst_sync;
    end else if (s.mod_on) begin
      if (s.mod_ext) begin
        run_sync = evt.carrier_high;
      end else begin
        run_sync = evt.mod_half;
      end
    end else begin
      run_sync = cont_sync;
    end
    next_s.sync_out = run_sync;

    // range: follow the request while automatic, otherwise hold
    if (s.auto_range) begin
      next_s.range_code = range_req;
    end

    // overload pin synchroniser
    next_s.ovl_pipe = {s.ovl_pipe[0], overload_pin};

    // register writes
    if (wr) begin
      case (req.paddr)
        OFS_CTRL: begin
          if (req.pwdata[CB_APPLY]) begin
            next_s.auto_range = 1'b1;
            next_s.out_en = 1'b1;
          end else begin
            next_s.auto_range = req.pwdata[CB_AUTO];
            next_s.out_en = req.pwdata[CB_OUT_EN];
          end
          next_s.invert = req.pwdata[CB_INV];
          next_s.sync_en = req.pwdata[CB_SYNC_EN];
          next_s.func = pso_func_t'(req.pwdata[CB_FUNC +: 3]);
          next_s.mod_on = req.pwdata[CB_MOD_ON];
          next_s.mod_ext = req.pwdata[CB_MOD_EXT];
          next_s.sweep_on = req.pwdata[CB_SWEEP];
          next_s.marker_on = req.pwdata[CB_MARKER];
          next_s.burst_on = req.pwdata[CB_BURST];
          next_s.burst_gated = req.pwdata[CB_GATED];
          next_s.burst_inf = req.pwdata[CB_INF];
        end
        // halves apply at once; the clamp covers the value between the two writes
        OFS_PER_LO: next_s.period[31:0] = req.pwdata;
        OFS_PER_HI: next_s.period[CNT_W-1:32] = req.pwdata[CNT_W-33:0];
        OFS_WID_LO: begin
          next_s.width[31:0] = req.pwdata;
          next_s.by_duty = 1'b0;
        end
        OFS_WID_HI: begin
          next_s.width[CNT_W-1:32] = req.pwdata[CNT_W-33:0];
          next_s.by_duty = 1'b0;
        end
        OFS_DUTY: begin
          // compare the whole word so an over-range duty saturates instead of wrapping
          if (req.pwdata > {25'h000_0000, DUTY_FULL}) begin
            next_s.duty = DUTY_FULL;
          end else begin
            next_s.duty = req.pwdata[6:0];
          end
          next_s.by_duty = 1'b1;
        end
        OFS_EDGE: begin
          if (req.pwdata == 32'h0000_0000) begin
            next_s.edge_set = EDGE_DEF_CYC;
          end else if (req.pwdata > {29'h0000_0000, EDGE_MAX_CYC}) begin
            next_s.edge_set = EDGE_MAX_CYC;
          end else begin
            next_s.edge_set = req.pwdata[2:0];
          end
        end
        OFS_STAT: begin
          // only the error flag is writable, and only to clear it
          if (req.pwdata[SB_OVL_ERR]) begin
            next_s.ovl_err = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // overload wins over any enable and over an error clear in the same cycle
    if (ovl_now) begin
      next_s.out_en = 1'b0;
      next_s.ovl_err = 1'b1;
    end

    // read data, captured in the setup cycle
    ctrl_rd = '0;
    ctrl_rd[CB_OUT_EN] = s.out_en;
    ctrl_rd[CB_AUTO] = s.auto_range;
    ctrl_rd[CB_INV] = s.invert;
    ctrl_rd[CB_SYNC_EN] = s.sync_en;
    ctrl_rd[CB_FUNC +: 3] = s.func;
    ctrl_rd[CB_MOD_ON] = s.mod_on;
    ctrl_rd[CB_MOD_EXT] = s.mod_ext;
    ctrl_rd[CB_SWEEP] = s.sweep_on;
    ctrl_rd[CB_MARKER] = s.marker_on;
    ctrl_rd[CB_BURST] = s.burst_on;
    ctrl_rd[CB_GATED] = s.burst_gated;
    ctrl_rd[CB_INF] = s.burst_inf;
    stat_rd = '0;
    stat_rd[SB_OVL_ERR] = s.ovl_err;
    stat_rd[SB_OVL_NOW] = ovl_now;
    stat_rd[SB_OUT_EN] = s.out_en;
    stat_rd[SB_RANGE +: RANGE_W] = s.range_code;
    stat_rd[SB_SYNC] = s.sync_out;
    stat_rd[SB_CLAMP] = s.clamped;
    stat_rd[SB_EDGE +: 3] = s.eff_edge;
    case (req.paddr)
      OFS_CTRL: rd = ctrl_rd;
      OFS_PER_LO: rd = s.period[31:0];
      OFS_PER_HI: rd = {{(64-CNT_W){1'b0}}, s.period[CNT_W-1:32]};
      OFS_WID_LO: rd = s.width[31:0];
      OFS_WID_HI: rd = {{(64-CNT_W){1'b0}}, s.width[CNT_W-1:32]};
      OFS_DUTY: rd = {25'h000_0000, s.duty};
      OFS_EDGE: rd = {29'h0000_0000, s.edge_set};
      OFS_STAT: rd = stat_rd;
      OFS_EWID_LO: rd = s.eff_width[31:0];
      OFS_EPER_LO: rd = s.eff_period[31:0];
      default: rd = 32'h0000_0000;
    endcase
    // answer one cycle after every setup; read data holds until the next setup
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    if (req.psel && !req.penable) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !fn_mapped(req.paddr);
      if (req.pwrite) begin
        next_s.prdata = 32'h0000_0000;
      end else begin
        next_s.prdata = rd;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.auto_range <= 1'b1;
      s.out_en <= 1'b0;
      s.sync_en <= 1'b1;
      s.func <= FN_PULSE;
      s.period <= P_PERIOD_DEF;
      s.width <= P_WIDTH_DEF;
      s.duty <= DUTY_DEF;
      s.edge_set <= EDGE_DEF_CYC;
      s.eff_period <= P_PERIOD_DEF;
      s.eff_width <= P_WIDTH_DEF;
      s.eff_edge <= EDGE_DEF_CYC;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign out_en = s.out_en;
  assign wave_invert = s.invert;
  assign range_code = s.range_code;
  assign edge_cycles = s.eff_edge;
  assign pulse_out = s.pulse_out;
  assign sync_out = s.sync_out;

endmodule // pso_output_ctrl

// >>> pso_output_ctrl_chk.sv
// port assertions and covers for the output-control block
`timescale 1ns/1ps
module pso_chk import pso_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic [RANGE_W-1:0] range_req,
  input wire logic overload_pin,
  input wire logic out_en,
  input wire logic [RANGE_W-1:0] range_code,
  input wire logic [2:0] edge_cycles
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  AST_RANGE_FOLLOW: assert property ($changed(range_code) |-> range_code == $past(range_req))
    else $error("range code moved to an unrequested value");
  AST_OUT_NO_WRITE: assert property (!out_en && !(psel && penable && pwrite) |=> !out_en)
    else $error("output enabled without a write");
  AST_OVL_OFF: assert property (overload_pin [*2] |-> ##2 !out_en)
    else $error("output still on during overload");
  AST_OVL_STAY: assert property (overload_pin [*3] ##1 !(psel && penable && pwrite) [*5] |-> !out_en)
    else $error("output came back after overload");
  AST_EDGE_LIMIT: assert property (edge_cycles inside {[3'h1:3'h5]})
    else $error("edge time out of range");
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  COV_OVL: cover property (overload_pin [*2] ##2 !out_en);
  COV_ERR: cover property (pslverr);
  COV_RANGE: cover property ($changed(range_code));
endmodule // pso_chk

bind pso_output_ctrl pso_chk i_chk (
  .clk_sys(clk_sys),
  .reset_n(reset_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pready(pready),
  .pslverr(pslverr),
  .range_req(range_req),
  .overload_pin(overload_pin),
  .out_en(out_en),
  .range_code(range_code),
  .edge_cycles(edge_cycles)
);

// >>> pso_output_ctrl_tb.sv
// self-checking bench for the output-control block
`timescale 1ns/1ps
module pso_output_ctrl_tb import pso_pkg::*; ;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pso_evt_t evt = '0;
  logic [RANGE_W-1:0] range_req = 3'h5;
  logic overload_pin;
  logic ovl_cmd = 1'b0;
  logic out_en;
  logic [RANGE_W-1:0] range_code;
  logic pulse_out;
  logic sync_out;
  logic wave_invert;
  logic [15:0] p_hi;
  logic [15:0] p_per;
  logic [15:0] s_hi;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int comparisons = 0;
  // write address, read address, write data, expected read
  logic [47:0] tbl [18] = '{48'h0424_0005_000a, 48'h0424_1388_0fa0, 48'h0424_000a_000a, 48'h0c20_0009_0008,
    48'h0424_0032_0032, 48'h0c20_0004_0004, 48'h181c_0005_0002, 48'h0c1c_0030_0001, 48'h1820_0001_0030,
    48'h0424_00c8_00c8, 48'h1420_0032_0064, 48'h1420_0000_000a, 48'h1420_0064_00be, 48'h1420_0096_00be,
    48'h0c20_0096_0096, 48'h0420_0064_0062, 48'h0424_00c8_00c8, 48'h0c20_0014_0014};
  always #10 clk_sys = ~clk_sys;
  pso_output_ctrl #(.P_PERIOD_MAX(36'h0fa0), .P_WSTEP_A(36'h0064), .P_WSTEP_B(36'h03e8),
    .P_PERIOD_DEF(36'h00c8), .P_WIDTH_DEF(36'h0014)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt(evt), .range_req(range_req), .overload_pin(overload_pin),
    .out_en(out_en), .wave_invert(wave_invert), .range_code(range_code), .edge_cycles(), .pulse_out(pulse_out),
    .sync_out(sync_out));
  pso_equip i_equip (.clk_sys(clk_sys), .reset_n(reset_n), .pulse_out(pulse_out), .sync_out(sync_out),
    .overload_pin(overload_pin), .ovl_cmd(ovl_cmd), .p_hi(p_hi), .p_per(p_per), .s_hi(s_hi));
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic ev(input pso_evt_t lv, input pso_evt_t pl, input logic exp);
    @(posedge clk_sys);
    evt <= lv | pl;
    @(posedge clk_sys);
    evt <= lv;
    cyc(2);
    chk("sync_out", sync_out, exp);
  endtask
  task automatic give_verdict();
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    cyc(1);
    chk("pulse_first", pulse_out, 1'b1);
    chk("out_en_reset", out_en, 1'b0);
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk("ctrl_reset", rd, 32'h0000_030a);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_data", rd, 32'h0000_0000);
    cyc(1);
    chk("range_auto", range_code, 3'h5);
    apb(1'b1, OFS_CTRL, 32'h0000_0308);
    range_req <= 3'h2;
    cyc(3);
    chk("range_hold", range_code, 3'h5);
    apb(1'b1, OFS_CTRL, 32'h0000_0318);
    cyc(2);
    chk("apply_range", range_code, 3'h2);
    chk("apply_out", out_en, 1'b1);
    foreach (tbl[i]) begin
      apb(1'b1, tbl[i][47:40], 32'(tbl[i][31:16]));
      apb(1'b0, tbl[i][39:32], 32'h0000_0000);
      chk("clamp", (tbl[i][39:32] == OFS_STAT) ? 32'(rd[10:8]) : rd, 32'(tbl[i][15:0]));
    end
    cyc(450);
    chk("pulse_high", p_hi, 16'h0014);
    chk("pulse_period", p_per, 16'h00c8);
    chk("sync_high", s_hi, 16'h0064);
    @(posedge sync_out);
    #1;
    chk("sync_phase", pulse_out, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h0000_030f);
    cyc(450);
    chk("inv_high", p_hi, 16'h00b4);
    chk("inv_sync", s_hi, 16'h0064);
    chk("wave_invert", wave_invert, 1'b1);
    @(posedge sync_out);
    #1;
    chk("inv_phase", pulse_out, 1'b0);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, OFS_CTRL, (k == 0) ? 32'h0000_0303 : 32'h0000_030b + 32'(k) * 32'h0000_0100);
      for (int j = 0; j < 25; j++) begin
        cyc(10);
        chk("sync_silent", sync_out, 1'b0);
      end
    end
    for (int f = 0; f < 3; f++) begin
      apb(1'b1, OFS_CTRL, 32'h0000_000b + 32'(f) * 32'h0000_0100);
      ev(11'h400, 11'h000, 1'b1);
      ev(11'h000, 11'h000, 1'b0);
    end
    apb(1'b1, OFS_CTRL, 32'h0000_060b);
    ev(11'h000, 11'h200, 1'b1);
    ev(11'h000, 11'h100, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0000_080b);
    ev(11'h400, 11'h000, 1'b0);
    ev(11'h080, 11'h000, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h0000_180b);
    ev(11'h080, 11'h000, 1'b0);
    ev(11'h400, 11'h000, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h0000_200b);
    ev(11'h000, 11'h040, 1'b1);
    ev(11'h000, 11'h010, 1'b1);
    ev(11'h000, 11'h020, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0000_6003);
    ev(11'h000, 11'h040, 1'b1);
    ev(11'h000, 11'h020, 1'b1);
    ev(11'h000, 11'h010, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0000_800b);
    ev(11'h000, 11'h008, 1'b1);
    ev(11'h000, 11'h004, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0002_800b);
    ev(11'h400, 11'h000, 1'b1);
    ev(11'h000, 11'h000, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0001_800b);
    ev(11'h002, 11'h000, 1'b1);
    ev(11'h000, 11'h000, 1'b1);
    ev(11'h000, 11'h001, 1'b0);
    @(posedge clk_sys);
    ovl_cmd <= 1'b1;
    cyc(4);
    chk("ovl_off", out_en, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0000_030b);
    cyc(2);
    chk("ovl_refuse", out_en, 1'b0);
    apb(1'b0, OFS_STAT, 32'h0000_0000);
    chk("ovl_flag", rd[1:0], 2'b11);
    ovl_cmd <= 1'b0;
    cyc(6);
    chk("ovl_stay", out_en, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0000_030b);
    cyc(1);
    chk("ovl_reenable", out_en, 1'b1);
    give_verdict();
  end
endmodule // pso_output_ctrl_tb

// >>> pso_pkg.sv
// package for the pulse, sync and output-control block: register map, fields, timing and state
// How it works
// - range follows the automatic request by default; holding keeps present amplifier setting
// - the apply command forces autoranging on and enables the main output
// - main output is disabled after reset until software enables it
// - overload sets an error, disables output; enable refused until overload is gone
// - inverted mode mirrors the pulse; normal mode starts each cycle high
// - inversion never changes the sync output
// - sync enabled by default, low when disabled, and silent for noise and dc; sweep with marker on still drives sync for noise and dc
// - sweep with marker ignores the sync enable; the marker drives sync
// - sine, ramp: sync is high while the output is above reference; pulse: sync is high for the first half of the period
// - square: sync follows the main output with the same duty cycle
// - arbitrary: sync rises at the first stored point, 50% duty
// - internal modulation: sync is high during the modulating waveform's first half
// - external modulation: sync follows the carrier with 50% duty
// - sweep, marker off: sync rises at sweep start, falls at the midpoint
// - sweep, marker on: sync rises at sweep start, falls at marker frequency
// - triggered burst: sync high from burst start to count done; infinite acts continuous
// - gated burst: sync follows gate but falls only after the last cycle ends
// - pulse period 200 ns to 1000 s, default 1 ms
// - period kept at least width plus 1.6 edge; width and edge shrink
// - width default 100 us; minimum width steps with period; width at most period minus minimum
// - width kept between 1.6 edge and period minus 1.6 edge
// - duty default 10%, clamped so the width meets minimum and edge limits
package pso_pkg;
  localparam int CNT_W = 36;
  localparam int RANGE_W = 3;
  localparam int CLK_NS = 20;
  // time figures in ns and the clock-cycle counts derived from them
  localparam longint PERIOD_MIN_NS = 200;
  localparam longint PERIOD_MAX_NS = 64'd1000_000_000_000;
  localparam longint PERIOD_DEF_NS = 1_000_000;
  localparam longint WIDTH_DEF_NS = 100_000;
  localparam longint WMIN_A_NS = 40;
  localparam longint WMIN_B_NS = 200;
  localparam longint WMIN_C_NS = 2_000;
  localparam longint WSTEP_A_NS = 64'd10_000_000_000;
  localparam longint WSTEP_B_NS = 64'd100_000_000_000;
  localparam longint EDGE_DEF_NS = 20;
  localparam longint EDGE_MAX_NS = 100;
  localparam logic [CNT_W-1:0] PERIOD_MIN_CYC = CNT_W'((PERIOD_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] PERIOD_MAX_CYC = CNT_W'(PERIOD_MAX_NS / CLK_NS);
  localparam logic [CNT_W-1:0] PERIOD_DEF_CYC = CNT_W'(PERIOD_DEF_NS / CLK_NS);
  localparam logic [CNT_W-1:0] WIDTH_DEF_CYC = CNT_W'(WIDTH_DEF_NS / CLK_NS);
  localparam logic [CNT_W-1:0] WMIN_A_CYC = CNT_W'((WMIN_A_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WMIN_B_CYC = CNT_W'((WMIN_B_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WMIN_C_CYC = CNT_W'((WMIN_C_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WSTEP_A_CYC = CNT_W'(WSTEP_A_NS / CLK_NS);
  localparam logic [CNT_W-1:0] WSTEP_B_CYC = CNT_W'(WSTEP_B_NS / CLK_NS);
  localparam logic [2:0] EDGE_DEF_CYC = 3'((EDGE_DEF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] EDGE_MAX_CYC = 3'(EDGE_MAX_NS / CLK_NS);
  localparam logic [6:0] DUTY_DEF = 7'h0a;
  localparam logic [6:0] DUTY_FULL = 7'h64;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PER_LO = 8'h04;
  localparam logic [7:0] OFS_PER_HI = 8'h08;
  localparam logic [7:0] OFS_WID_LO = 8'h0c;
  localparam logic [7:0] OFS_WID_HI = 8'h10;
  localparam logic [7:0] OFS_DUTY = 8'h14;
  localparam logic [7:0] OFS_EDGE = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1c;
  localparam logic [7:0] OFS_EWID_LO = 8'h20;
  localparam logic [7:0] OFS_EPER_LO = 8'h24;
  // control register fields
  localparam int CB_OUT_EN = 0;
  localparam int CB_AUTO = 1;
  localparam int CB_INV = 2;
  localparam int CB_SYNC_EN = 3;
  localparam int CB_APPLY = 4;
  localparam int CB_FUNC = 8;
  localparam int CB_MOD_ON = 11;
  localparam int CB_MOD_EXT = 12;
  localparam int CB_SWEEP = 13;
  localparam int CB_MARKER = 14;
  localparam int CB_BURST = 15;
  localparam int CB_GATED = 16;
  localparam int CB_INF = 17;
  // status register fields
  localparam int SB_OVL_ERR = 0;
  localparam int SB_OVL_NOW = 1;
  localparam int SB_OUT_EN = 2;
  localparam int SB_RANGE = 3;
  localparam int SB_SYNC = 6;
  localparam int SB_CLAMP = 7;
  localparam int SB_EDGE = 8;

  typedef enum logic [2:0] {FN_SINE, FN_SQUARE, FN_RAMP, FN_PULSE, FN_NOISE, FN_DC, FN_ARB} pso_func_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pso_apb_req_t;

  typedef struct packed {
    logic carrier_high;
    logic arb_first;
    logic arb_half;
    logic mod_half;
    logic sweep_start;
    logic sweep_mid;
    logic sweep_marker;
    logic burst_start;
    logic burst_done;
    logic gate;
    logic cycle_end;
  } pso_evt_t;

  typedef struct packed {
    logic out_en;
    logic auto_range;
    logic invert;
    logic sync_en;
    pso_func_t func;
    logic mod_on;
    logic mod_ext;
    logic sweep_on;
    logic marker_on;
    logic burst_on;
    logic burst_gated;
    logic burst_inf;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] width;
    logic [6:0] duty;
    logic [2:0] edge_set;
    logic by_duty;
    logic [CNT_W-1:0] eff_period;
    logic [CNT_W-1:0] eff_width;
    logic [2:0] eff_edge;
    logic clamped;
    logic [CNT_W-1:0] cnt;
    logic pulse_out;
    logic sync_out;
    logic sweep_sync;
    logic burst_sync;
    logic arb_sync;
    logic [1:0] ovl_pipe;
    logic ovl_err;
    logic [RANGE_W-1:0] range_code;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pso_state_t;
endpackage
